/* File: logic/sfr_fade_ctrl.v */
`timescale 1ns/1ns
`include "sfr_regs.vh"

module sfr_fade_ctrl #(
   parameter CLK_HZ = 50000000,
   parameter [6:0] DEV_ADDR = 7'h2a
) (
   // Clock and reset
   input wire clk_sys,
   input wire arst_n,
   // Serial interface pins
   input wire scl,
   input wire sda_in,
   output wire sda_out,
   output reg sda_oe,
   // Sink control
   input wire sink_on,
   output wire [6:0] sink_level,
   output reg sink_range,
   output wire fade_busy
);

   // ---------------------------------------------------------------
   // States
   // ---------------------------------------------------------------
   localparam [8:0] ST_IDLE = 9'h001;
   localparam [8:0] ST_ADDR = 9'h002;
   localparam [8:0] ST_ADDR_ACK = 9'h004;
   localparam [8:0] ST_PTR = 9'h008;
   localparam [8:0] ST_PTR_ACK = 9'h010;
   localparam [8:0] ST_WDATA = 9'h020;
   localparam [8:0] ST_WDATA_ACK = 9'h040;
   localparam [8:0] ST_RDATA = 9'h080;
   localparam [8:0] ST_RDATA_ACK = 9'h100;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   reg [7:0] sink_fade_rates;
   reg [7:0] seventh_sink_current;
   reg [7:0] ptr;

   function [7:0] rd_reg;
      input [7:0] addr;
      begin
         case (addr)
            `SFR_ADDR_FADE_RATES: rd_reg = sink_fade_rates;
            `SFR_ADDR_SEVENTH_CUR: rd_reg = seventh_sink_current;
            default: rd_reg = 8'h00;
         endcase
      end
   endfunction

   // Byte at the pointer, loaded into the shifter at each read byte
   wire [7:0] rd_byte = rd_reg(ptr);

   // ---------------------------------------------------------------
   // Pin synchronisers and bus events
   // ---------------------------------------------------------------
   reg scl_s1, scl_s2, scl_d;
   reg sda_s1, sda_s2, sda_d;

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_s1 <= scl;
         scl_s2 <= scl_s1;
         scl_d <= scl_s2;
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
         sda_d <= sda_s2;
      end
   end

   wire scl_rise = scl_s2 & ~scl_d;
   wire scl_fall = ~scl_s2 & scl_d;
   wire bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
   wire bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;

   assign sda_out = 1'b0;

   // ---------------------------------------------------------------
   // Serial slave
   // ---------------------------------------------------------------
   reg [8:0] state;
   reg [7:0] shreg;
   reg [3:0] bitcnt;
   reg rw;
   reg nack;

   wire rx_state = (state == ST_ADDR) | (state == ST_PTR) |
      (state == ST_WDATA);
   wire byte_done = bitcnt == `SFR_BITS_PER_BYTE;

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_IDLE;
         shreg <= 8'h00;
         bitcnt <= `SFR_BIT_RST;
         rw <= 1'b0;
         nack <= 1'b0;
         sda_oe <= 1'b0;
         ptr <= `SFR_PTR_RST;
         sink_fade_rates <= `SFR_RST_FADE_RATES;
         seventh_sink_current <= `SFR_RST_SEVENTH_CUR;
      end else if (bus_start) begin
         state <= ST_ADDR;
         bitcnt <= `SFR_BIT_RST;
         sda_oe <= 1'b0;
      end else if (bus_stop) begin
         state <= ST_IDLE;
         sda_oe <= 1'b0;
      end else if (scl_rise) begin
         if (rx_state) begin
            shreg <= {shreg[6:0], sda_s2};
            bitcnt <= bitcnt + 4'h1;
         end else if (state == ST_RDATA_ACK) begin
            nack <= sda_s2;
         end
      end else if (scl_fall) begin
         case (state)
            ST_ADDR: begin
               if (byte_done) begin
                  if (shreg[7:1] == DEV_ADDR) begin
                     rw <= shreg[0];
                     sda_oe <= 1'b1;
                     state <= ST_ADDR_ACK;
                  end else begin
                     state <= ST_IDLE;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (rw) begin
                  sda_oe <= ~rd_byte[7];
                  shreg <= {rd_byte[6:0], 1'b0};
                  bitcnt <= `SFR_BIT_FIRST;
                  state <= ST_RDATA;
               end else begin
                  sda_oe <= 1'b0;
                  bitcnt <= `SFR_BIT_RST;
                  state <= ST_PTR;
               end
            end
            ST_PTR: begin
               if (byte_done) begin
                  ptr <= shreg;
                  sda_oe <= 1'b1;
                  state <= ST_PTR_ACK;
               end
            end
            ST_WDATA: begin
               if (byte_done) begin
                  case (ptr)
                     `SFR_ADDR_FADE_RATES: sink_fade_rates <= shreg;
                     `SFR_ADDR_SEVENTH_CUR:
                        seventh_sink_current <= shreg;
                     default: ;
                  endcase
                  ptr <= ptr + 8'h01;
                  sda_oe <= 1'b1;
                  state <= ST_WDATA_ACK;
               end
            end
            ST_PTR_ACK, ST_WDATA_ACK: begin
               sda_oe <= 1'b0;
               bitcnt <= `SFR_BIT_RST;
               state <= ST_WDATA;
            end
            ST_RDATA: begin
               if (byte_done) begin
                  sda_oe <= 1'b0;
                  ptr <= ptr + 8'h01;
                  state <= ST_RDATA_ACK;
               end else begin
                  sda_oe <= ~shreg[7];
                  shreg <= {shreg[6:0], 1'b0};
                  bitcnt <= bitcnt + 4'h1;
               end
            end
            ST_RDATA_ACK: begin
               if (nack) begin
                  state <= ST_IDLE;
               end else begin
                  sda_oe <= ~rd_byte[7];
                  shreg <= {rd_byte[6:0], 1'b0};
                  bitcnt <= `SFR_BIT_FIRST;
                  state <= ST_RDATA;
               end
            end
            default: begin
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Sink range and fade engine
   // ---------------------------------------------------------------
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sink_range <= 1'b0;
      end else begin
         sink_range <= seventh_sink_current[`SFR_RANGE_BIT];
      end
   end

   wire [6:0] seventh_current_code =
      seventh_sink_current[`SFR_CODE_HI:`SFR_CODE_LO];
   wire [3:0] fade_out_rate =
      sink_fade_rates[`SFR_FADE_OUT_HI:`SFR_FADE_OUT_LO];
   wire [3:0] fade_in_rate =
      sink_fade_rates[`SFR_FADE_IN_HI:`SFR_FADE_IN_LO];

   sfr_fade_ramp #(
      .CLK_HZ(CLK_HZ)
   ) u_ramp (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .target(sink_on ? seventh_current_code : `SFR_CODE_ZERO),
      .fade_in_rate(fade_in_rate),
      .fade_out_rate(fade_out_rate),
      .level(sink_level),
      .busy(fade_busy)
   );

endmodule

/* File: logic/sfr_regs.vh */
`ifndef SFR_REGS_VH
`define SFR_REGS_VH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define SFR_ADDR_FADE_RATES 8'h13
`define SFR_ADDR_SEVENTH_CUR 8'h14
`define SFR_RST_FADE_RATES 8'h00
`define SFR_RST_SEVENTH_CUR 8'h00
`define SFR_PTR_RST 8'h00

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SFR_FADE_OUT_HI 7
`define SFR_FADE_OUT_LO 4
`define SFR_FADE_IN_HI 3
`define SFR_FADE_IN_LO 0
`define SFR_RANGE_BIT 7
`define SFR_CODE_HI 6
`define SFR_CODE_LO 0

// ---------------------------------------------------------------
// Fade timing
// ---------------------------------------------------------------
`define SFR_RATE_OFF 4'h0
`define SFR_SHORT_LAST 4'ha
`define SFR_STEP_SHORT_MS 13'd300
`define SFR_STEP_LONG_MS 13'd500
`define SFR_SHORT_END_MS 13'd3000
`define SFR_FULL_SCALE 13'd127
`define SFR_MS_PER_S 1000
`define SFR_CODE_ZERO 7'h00

// ---------------------------------------------------------------
// Serial interface
// ---------------------------------------------------------------
`define SFR_BITS_PER_BYTE 4'h8
`define SFR_BIT_FIRST 4'h1
`define SFR_BIT_RST 4'h0

`endif

/* File: logic/sfr_fade_ramp.v */
`timescale 1ns/1ns
`include "sfr_regs.vh"

module sfr_fade_ramp #(
   parameter CLK_HZ = 50000000
) (
   // Clock and reset
   input wire clk_sys,
   input wire arst_n,
   // Settings
   input wire [6:0] target,
   input wire [3:0] fade_in_rate,
   input wire [3:0] fade_out_rate,
   // Ramp output
   output reg [6:0] level,
   output wire busy
);

   localparam integer CYC_PER_MS = CLK_HZ / `SFR_MS_PER_S;
   localparam integer MS_LAST_I = CYC_PER_MS - 1;
   localparam [15:0] MS_LAST = MS_LAST_I[15:0];

   // ---------------------------------------------------------------
   // Full-scale duration in ms for a rate code
   // ---------------------------------------------------------------
   function [12:0] dur_ms;
      input [3:0] code;
      begin
         if (code <= `SFR_SHORT_LAST) begin
            dur_ms = `SFR_STEP_SHORT_MS * {9'h000, code};
         end else begin
            dur_ms = `SFR_SHORT_END_MS + `SFR_STEP_LONG_MS *
               {9'h000, code - `SFR_SHORT_LAST};
         end
      end
   endfunction

   // ---------------------------------------------------------------
   // Millisecond tick
   // ---------------------------------------------------------------
   reg [15:0] ms_cnt;
   reg ms_tick;

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ms_cnt <= 16'h0000;
         ms_tick <= 1'b0;
      end else if (ms_cnt == MS_LAST) begin
         ms_cnt <= 16'h0000;
         ms_tick <= 1'b1;
      end else begin
         ms_cnt <= ms_cnt + 16'h0001;
         ms_tick <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Ramp: full scale per duration, one code step at a time; rate code 0 jumps straight to target
   // ---------------------------------------------------------------
   wire going_up = target > level;
   wire [3:0] rate = going_up ? fade_in_rate : fade_out_rate;
   wire [12:0] dur = dur_ms(rate);
   wire [12:0] acc_sum;
   reg [12:0] acc;

   assign acc_sum = acc + `SFR_FULL_SCALE;
   assign busy = level != target;

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         level <= `SFR_CODE_ZERO;
         acc <= 13'h0000;
      end else if (!busy) begin
         acc <= 13'h0000;
      end else if (rate == `SFR_RATE_OFF) begin
         level <= target;
         acc <= 13'h0000;
      end else if (ms_tick) begin
         // Fixed rate per code step, so short fades end early
         if (acc_sum >= dur) begin
            acc <= acc_sum - dur;
            level <= going_up ? level + 7'h01 : level - 7'h01;
         end else begin
            acc <= acc_sum;
         end
      end
   end

endmodule

/* File: verif/sfr_host_model.sv */
`timescale 1ns/1ns
module sfr_host_model (
   // Clock
   input wire clk_sys,
   // Serial pins
   input wire sda,
   output reg scl,
   output reg sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Half phase, kept above the 4-cycle minimum
   task hp;
      repeat (5) @(posedge clk_sys);
   endtask
   task start;
      begin
         hp;
         sda_low <= 1'b0;
         hp;
         scl <= 1'b1;
         hp;
         sda_low <= 1'b1;
         hp;
         scl <= 1'b0;
      end
   endtask
   task stop;
      begin
         hp;
         sda_low <= 1'b1;
         hp;
         scl <= 1'b1;
         hp;
         sda_low <= 1'b0;
         hp;
      end
   endtask
   // Byte out MSB first, ninth bit on the acknowledge slot
   task automatic xfer(input logic [7:0] d, input logic ninth,
                       output logic [7:0] q, output logic ack);
      integer i;
      logic [8:0] w;
      begin
         w = {d, ninth};
         for (i = 8; i >= 0; i = i - 1) begin
            hp;
            sda_low <= ~w[i];
            hp;
            scl <= 1'b1;
            hp;
            w[i] = sda;
            scl <= 1'b0;
         end
         q = w[8:1];
         ack = ~w[0];
      end
   endtask
endmodule

/* File: verif/sfr_fade_ctrl_asserts.sv */
`timescale 1ns/1ns
module sfr_fade_ctrl_asserts (
   // Clock and reset
   input wire clk_sys,
   input wire arst_n,
   // Serial pins
   input wire scl,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe,
   // Sink control
   input wire sink_on,
   input wire [6:0] sink_level,
   input wire sink_range,
   input wire fade_busy
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   chk_pin_low: assert property (sda_out == 1'b0)
      else $error("sda_out not low");
   chk_reset_idle: assert property ($rose(arst_n) |->
      !sda_oe && sink_level == 7'h00 && !sink_range)
      else $error("outputs not idle after reset");
   chk_ack_rise: assert property ($rose(sda_oe) |-> !scl)
      else $error("sda driven while scl high");
   chk_ack_fall: assert property ($fell(sda_oe) |-> !scl)
      else $error("sda released while scl high");
   chk_oe_hold: assert property (scl && $past(scl) |-> $stable(sda_oe))
      else $error("sda changed during scl high");
   chk_range_move: assert property ($changed(sink_range) |-> !scl)
      else $error("range changed outside byte end");
   chk_unit_step: assert property (fade_busy && $changed(sink_level) |->
      sink_level == $past(sink_level) + 7'h01 ||
      sink_level + 7'h01 == $past(sink_level))
      else $error("ramp step not one code");
   chk_ramp_gap: assert property (fade_busy && $changed(sink_level) |=>
      $stable(sink_level) [*8])
      else $error("ramp steps too close");
   chk_idle_still: assert property (!fade_busy ##1 !fade_busy |->
      $stable(sink_level))
      else $error("level moved while idle");
endmodule
bind sfr_fade_ctrl sfr_fade_ctrl_asserts u_chk (.clk_sys(clk_sys),
   .arst_n(arst_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .sink_on(sink_on), .sink_level(sink_level),
   .sink_range(sink_range), .fade_busy(fade_busy));

/* File: verif/sfr_fade_ctrl_tb_top.sv */
`timescale 1ns/1ns
module sfr_fade_ctrl_tb_top;
   localparam [6:0] DEV = 7'h2a;
   reg clk_sys = 1'b0;
   reg arst_n = 1'b0;
   reg sink_on = 1'b0;
   wire scl, host_low, sda_oe, sda_out, sink_range, fade_busy;
   wire [6:0] sink_level;
   wire sda = ~(host_low | sda_oe);
   integer n_mismatch = 0;
   integer n_tests = 0;
   integer c;
   always #10 clk_sys = ~clk_sys;
   // Millisecond tick of 127 cycles: a fade of d ms over s codes is d*s
   sfr_fade_ctrl #(.CLK_HZ(127000), .DEV_ADDR(DEV)) dut (.clk_sys(clk_sys),
      .arst_n(arst_n), .scl(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .sink_on(sink_on), .sink_level(sink_level),
      .sink_range(sink_range), .fade_busy(fade_busy));
   sfr_host_model host (.clk_sys(clk_sys), .sda(sda), .scl(scl),
      .sda_low(host_low));
   task close_out;
      begin
         $display("tests %0d mismatches %0d", n_tests, n_mismatch);
         if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   task chk(input logic [8:0] got, input logic [8:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task chk_time(input integer got, input integer exp, input integer tol);
      begin
         n_tests = n_tests + 1;
         if (got < exp - tol || got > exp + tol) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %0t fade %0d cycles exp %0d", $time, got, exp);
         end
      end
   endtask
   function integer dur(input integer k);
      dur = (k <= 10) ? 300 * k : 3000 + 500 * (k - 10);
   endfunction
   task wr(input logic [7:0] p, input logic [7:0] d);
      logic [7:0] q;
      logic a;
      begin
         host.start;
         host.xfer({DEV, 1'b0}, 1'b1, q, a);
         chk(a, 1'b1);
         host.xfer(p, 1'b1, q, a);
         host.xfer(d, 1'b1, q, a);
         chk(a, 1'b1);
         host.stop;
      end
   endtask
   // Two-byte burst read: checks pointer increment as well
   task rd(input logic [7:0] p, input logic [7:0] e0, input logic [7:0] e1);
      logic [7:0] q;
      logic a;
      begin
         host.start;
         host.xfer({DEV, 1'b0}, 1'b1, q, a);
         host.xfer(p, 1'b1, q, a);
         host.start;
         host.xfer({DEV, 1'b1}, 1'b1, q, a);
         host.xfer(8'hff, 1'b0, q, a);
         chk(q, e0);
         host.xfer(8'hff, 1'b1, q, a);
         chk(q, e1);
         host.stop;
      end
   endtask
   task t_regs;
      logic [7:0] q;
      logic a;
      begin
         chk({sda_oe, sink_range, sink_level}, 9'h000);
         rd(8'h13, 8'h00, 8'h00);
         for (c = 0; c < 16; c = c + 1) begin
            wr(8'h13, {c[3:0], 4'hf - c[3:0]});
            rd(8'h13, {c[3:0], 4'hf - c[3:0]}, 8'h00);
         end
         wr(8'h14, 8'h85);
         rd(8'h14, 8'h85, 8'h00);
         chk(sink_range, 1'b1);
         wr(8'h14, 8'h05);
         chk(sink_range, 1'b0);
         host.start;
         host.xfer({7'h2b, 1'b0}, 1'b1, q, a);
         chk(a, 1'b0);
         host.stop;
      end
   endtask
   task t_jump;
      begin
         wr(8'h13, 8'h00);
         wr(8'h14, 8'h0a);
         sink_on <= 1'b1;
         repeat (3) @(posedge clk_sys);
         chk({fade_busy, sink_level}, 9'h00a);
         sink_on <= 1'b0;
         repeat (3) @(posedge clk_sys);
         chk({fade_busy, sink_level}, 9'h000);
      end
   endtask
   task settle(input integer lvl, input integer exp, input integer span);
      integer n;
      begin
         n = 2;
         repeat (2) @(posedge clk_sys);
         while (fade_busy !== 1'b0 && n < 60000) begin
            @(posedge clk_sys);
            n = n + 1;
         end
         if (n >= 60000) begin
            n_mismatch = n_mismatch + 1;
            close_out;
         end else begin
            chk(sink_level, lvl);
            chk_time(n, exp, exp / span + 300);
         end
      end
   endtask
   task t_fade(input integer fi, input integer fo, input integer span);
      begin
         wr(8'h14, span[7:0]);
         wr(8'h13, {fo[3:0], fi[3:0]});
         sink_on <= 1'b1;
         settle(span, dur(fi) * span, span);
         sink_on <= 1'b0;
         settle(0, dur(fo) * span, span);
      end
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      t_regs;
      t_jump;
      t_fade(1, 11, 10);
      t_fade(15, 2, 2);
      close_out;
   end
endmodule
